// ==== hw/hcsr_regs.sv ====
// Purpose: Hub configuration and string register bank with descriptor readout.
// Assumes: Configuration port driven by the SMBus slave or EEPROM loader on i_clk.
// Notes:   Read data appears one cycle after the read strobe.
`timescale 1ns/100ps
module hcsr_regs
    import hcsr_pkg::*;
#(
    parameter int           NUM_PORTS      = HCSR_NUM_PORTS,
    // Arbitrary factory serial pattern; replace per product.
    parameter logic [255:0] SERIAL_DEFAULT = {32{8'h5A}}
)
(
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    input  wire logic       i_cfg_wr,
    input  wire logic       i_cfg_rd,
    input  wire logic [7:0] i_cfg_addr,
    input  wire logic [7:0] i_cfg_wdata,
    output logic      [7:0] o_cfg_rdata,
    output logic            o_cfg_rvalid,
    input  wire logic       i_custom_removable_control,
    input  wire logic       i_custom_serial_control,
    input  wire logic       i_custom_strings_control,
    input  wire logic       i_fuse_hub_legacy_only,
    input  wire logic       i_fuse_full_auto_divider_charging,
    input  wire logic [3:0] i_port_flag_a,
    input  wire logic [3:0] i_port_charge_enable,
    input  wire logic       i_auto_charge_active,
    input  wire logic [3:0] i_charge_attempt_fail,
    output logic            o_ss_speed_5g_supported,
    output logic            o_ss_hub_enable,
    output logic      [3:0] o_port_legacy_only,
    output logic      [3:0] o_port_ss_enable,
    output logic      [7:0] o_port_charge_mode,
    input  wire logic       i_desc_req,
    input  wire logic [7:0] i_desc_index,
    input  wire logic       i_desc_ready,
    output logic            o_desc_valid,
    output logic      [7:0] o_desc_byte,
    output logic            o_desc_last,
    output logic            o_desc_busy,
    output logic            o_desc_none
);
    // -------------------------------------------------------------------------
    // Elaboration checks
    // -------------------------------------------------------------------------
    if (NUM_PORTS != HCSR_NUM_PORTS) begin : g_bad_ports
        $error("port count must match the four-bit port register");
    end

    // -------------------------------------------------------------------------
    // Decode helpers
    // -------------------------------------------------------------------------
    function automatic logic in_range(input logic [7:0] a, input logic [7:0] base,
                                      input int n);
        logic [8:0] top;
        top = 9'({1'b0, base} + 9'(n));
        return (a >= base) && ({1'b0, a} < top);
    endfunction

    // -------------------------------------------------------------------------
    // Storage
    // -------------------------------------------------------------------------
    logic       legacy_r;
    logic       full_auto_r;
    logic [3:0] port_legacy_r;
    logic [6:0] vendor_len_r;
    logic [7:0] serial_r [HCSR_SERIAL_BYTES];
    logic [7:0] vendor_r [HCSR_VENDOR_BYTES];
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic       rvalid_r;

    // -------------------------------------------------------------------------
    // Address decode
    // -------------------------------------------------------------------------
    wire        hit_cfg3   = i_cfg_addr == HCSR_OFF_DEV_CFG3;
    wire        hit_port   = i_cfg_addr == HCSR_OFF_PORT_LEGACY;
    wire        hit_vlen   = i_cfg_addr == HCSR_OFF_VENDOR_LEN;
    wire        hit_ser    = in_range(i_cfg_addr, HCSR_OFF_SERIAL_BASE, HCSR_SERIAL_BYTES);
    wire        hit_ven    = in_range(i_cfg_addr, HCSR_OFF_VENDOR_BASE, HCSR_VENDOR_BYTES);
    wire [7:0]  ser_off    = 8'(i_cfg_addr - HCSR_OFF_SERIAL_BASE);
    wire [7:0]  ven_off    = 8'(i_cfg_addr - HCSR_OFF_VENDOR_BASE);
    wire [4:0]  ser_idx    = ser_off[4:0];
    wire [5:0]  ven_idx    = ven_off[5:0];
    wire        wr_cfg3    = i_cfg_wr && hit_cfg3;
    wire        wr_port    = i_cfg_wr && hit_port && i_custom_removable_control; // see [R4]
    wire        wr_vlen    = i_cfg_wr && hit_vlen && i_custom_strings_control;
    wire        wr_ser     = i_cfg_wr && hit_ser && i_custom_serial_control; // see [R8]
    wire        wr_ven     = i_cfg_wr && hit_ven;
    // Oversized lengths are clamped so the streamer never walks off the array.
    wire [6:0]  vlen_in    = (i_cfg_wdata[6:0] > HCSR_VENDOR_LEN_MAX) ?
                             HCSR_VENDOR_LEN_MAX : i_cfg_wdata[6:0]; // see [R11]

    // -------------------------------------------------------------------------
    // Effective feature bits
    // -------------------------------------------------------------------------
    wire        legacy_eff = legacy_r || i_fuse_hub_legacy_only; // see [R2]
    wire        auto_eff   = full_auto_r || i_fuse_full_auto_divider_charging;

    // -------------------------------------------------------------------------
    // Control registers
    // -------------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            legacy_r      <= HCSR_CFG3_BIT_RST;
            full_auto_r   <= HCSR_CFG3_BIT_RST;
            port_legacy_r <= HCSR_PORT_LEGACY_RST;
            vendor_len_r  <= HCSR_VENDOR_LEN_RST; // see [R11]
        end else begin
            if (wr_cfg3) begin
                legacy_r    <= i_cfg_wdata[HCSR_CFG3_LEGACY_BIT];
                full_auto_r <= i_cfg_wdata[HCSR_CFG3_AUTO_BIT];
            end
            if (wr_port) begin
                port_legacy_r <= i_cfg_wdata[3:0]; // see [R10]
            end
            if (wr_vlen) begin
                vendor_len_r <= vlen_in;
            end
        end
    end

    // -------------------------------------------------------------------------
    // String arrays
    // -------------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            for (int i = 0; i < HCSR_SERIAL_BYTES; i++) begin
                serial_r[i] <= SERIAL_DEFAULT[8*i +: 8]; // see [R8]
            end
        end else if (wr_ser) begin
            serial_r[ser_idx] <= i_cfg_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            for (int i = 0; i < HCSR_VENDOR_BYTES; i++) begin
                vendor_r[i] <= HCSR_VENDOR_BYTE_RST;
            end
        end else if (wr_ven) begin
            vendor_r[ven_idx] <= i_cfg_wdata;
        end
    end

    // -------------------------------------------------------------------------
    // Read path
    // -------------------------------------------------------------------------
    always_comb begin
        rdata_nxt = 8'h00;
        if (hit_cfg3) begin
            rdata_nxt[HCSR_CFG3_LEGACY_BIT] = legacy_eff; // see [R2]
            rdata_nxt[HCSR_CFG3_AUTO_BIT]   = auto_eff;
        end else if (hit_port) begin
            rdata_nxt = {4'h0, port_legacy_r}; // see [R10]
        end else if (hit_vlen) begin
            rdata_nxt = {1'b0, vendor_len_r};
        end else if (hit_ser) begin
            rdata_nxt = serial_r[ser_idx];
        end else if (hit_ven) begin
            rdata_nxt = vendor_r[ven_idx];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= i_cfg_rd;
            if (i_cfg_rd) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    assign o_cfg_rdata  = rdata_r;
    assign o_cfg_rvalid = rvalid_r;

    // -------------------------------------------------------------------------
    // Hub and port configuration
    // -------------------------------------------------------------------------
    assign o_ss_speed_5g_supported = !legacy_eff; // see [R1]
    assign o_ss_hub_enable         = !legacy_eff;
    assign o_port_legacy_only      = port_legacy_r; // see [R6]
    // The legacy bit wins over the port-port_flag_a flag for SuperSpeed enable.
    assign o_port_ss_enable        = i_port_flag_a & ~port_legacy_r; // see [R5]

    // -------------------------------------------------------------------------
    // Charging sequencers
    // -------------------------------------------------------------------------
    for (genvar p = 0; p < HCSR_NUM_PORTS; p++) begin : g_chg
        hcsr_charge_seq u_seq (
            .i_clk          (i_clk),
            .i_reset        (i_reset),
            .i_active       (i_auto_charge_active && i_port_charge_enable[p]),
            .i_full_auto    (auto_eff), // see [R3]
            .i_attempt_fail (i_charge_attempt_fail[p]),
            .o_mode         (o_port_charge_mode[2*p +: 2])
        );
    end

    // -------------------------------------------------------------------------
    // Descriptor readout
    // -------------------------------------------------------------------------
    logic       desc_src;
    logic [6:0] desc_ptr;
    wire  [7:0] desc_src_byte = desc_src ? vendor_r[desc_ptr[5:0]]
                                         : serial_r[desc_ptr[4:0]]; // see [R7]

    hcsr_desc_stream u_stream (
        .i_clk        (i_clk),
        .i_reset      (i_reset),
        .i_req        (i_desc_req),
        .i_index      (i_desc_index),
        .i_vendor_len (vendor_len_r),
        .i_ready      (i_desc_ready),
        .i_byte       (desc_src_byte),
        .o_src        (desc_src),
        .o_ptr        (desc_ptr),
        .o_busy       (o_desc_busy),
        .o_valid      (o_desc_valid),
        .o_byte       (o_desc_byte),
        .o_last       (o_desc_last),
        .o_none       (o_desc_none)
    );

    // -------------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------------
    wire desc_idle = !o_desc_busy && !o_desc_valid;

    property p_speed_cleared;
        @(posedge i_clk) disable iff (i_reset)
        wr_cfg3 && i_cfg_wdata[HCSR_CFG3_LEGACY_BIT] |=> !o_ss_speed_5g_supported;
    endproperty
    a_speed_cleared: assert property (p_speed_cleared) else $error("5G flag not cleared"); // see [R1]

    property p_read_or;
        @(posedge i_clk) disable iff (i_reset)
        i_cfg_rd && hit_cfg3 && i_fuse_hub_legacy_only
            |=> o_cfg_rvalid && o_cfg_rdata[HCSR_CFG3_LEGACY_BIT];
    endproperty
    a_read_or: assert property (p_read_or) else $error("fuse not ORed into read"); // see [R2]

    property p_port_locked;
        @(posedge i_clk) disable iff (i_reset)
        i_cfg_wr && hit_port && !i_custom_removable_control |=> $stable(port_legacy_r);
    endproperty
    a_port_locked: assert property (p_port_locked) else $error("locked port field written"); // see [R4]

    property p_port_override;
        @(posedge i_clk) disable iff (i_reset)
        o_port_ss_enable == (i_port_flag_a & ~o_port_legacy_only);
    endproperty
    a_port_override: assert property (p_port_override) else $error("port override wrong"); // see [R5]

    property p_legacy_port;
        @(posedge i_clk) disable iff (i_reset)
        wr_port ##1 o_port_legacy_only[0] |-> !o_port_ss_enable[0];
    endproperty
    a_legacy_port: assert property (p_legacy_port) else $error("legacy port has SS"); // see [R6]

    property p_serial_first;
        @(posedge i_clk) disable iff (i_reset)
        i_desc_req && desc_idle && i_desc_index == HCSR_STR_IDX_SERIAL && !i_cfg_wr
            |=> ##1 o_desc_valid && o_desc_byte == $past(serial_r[0]);
    endproperty
    a_serial_first: assert property (p_serial_first) else $error("serial byte 0 wrong"); // see [R7]

    property p_serial_locked;
        @(posedge i_clk) disable iff (i_reset)
        i_cfg_wr && i_cfg_addr == HCSR_OFF_SERIAL_BASE && !i_custom_serial_control
            |=> $stable(serial_r[0]);
    endproperty
    a_serial_locked: assert property (p_serial_locked) else $error("serial written locked"); // see [R8]

    property p_vendor_absent;
        @(posedge i_clk) disable iff (i_reset)
        i_desc_req && desc_idle && i_desc_index == HCSR_STR_IDX_VENDOR && vendor_len_r == 7'h00
            |=> o_desc_none && !o_desc_busy;
    endproperty
    a_vendor_absent: assert property (p_vendor_absent) else $error("empty vendor served"); // see [R9]

    property p_reserved_zero;
        @(posedge i_clk) disable iff (i_reset)
        i_cfg_rd && hit_port |=> o_cfg_rdata[7:4] == 4'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set"); // see [R10]

    property p_len_max;
        @(posedge i_clk) disable iff (i_reset)
        vendor_len_r <= HCSR_VENDOR_LEN_MAX;
    endproperty
    a_len_max: assert property (p_len_max) else $error("vendor length above 64"); // see [R11]

    c_serial_done: cover property (@(posedge i_clk) disable iff (i_reset)
        o_desc_valid && o_desc_last && i_desc_ready && !desc_src);
    c_vendor_done: cover property (@(posedge i_clk) disable iff (i_reset)
        o_desc_valid && o_desc_last && i_desc_ready && desc_src);
    c_legacy_set: cover property (@(posedge i_clk) disable iff (i_reset)
        !o_ss_speed_5g_supported);
    c_refused: cover property (@(posedge i_clk) disable iff (i_reset) o_desc_none);
endmodule

// ==== hw/hcsr_pkg.sv ====
// Purpose: Constants and types shared by the hub configuration string registers.
// Assumes: Byte-wide registers at byte offsets on the configuration port.
// Notes:   Summary of operation follows.
//
// Summary of operation
// [R1] Hub legacy-only clears the 5 Gbps speed flag.
// [R2] Legacy-only bit 4 reads stored OR fuse.
// [R3] Full-auto tries divider modes high first, then low, then DCP.
// [R4] Port legacy bits writable only with custom-removable.
// [R5] Port legacy bit overrides its port-port_flag_a flag.
// [R6] Legacy bit one means USB 2.0 only.
// [R7] Serial bytes served at string index 1.
// [R8] Serial bytes default; writable with custom-serial.
// [R9] Vendor string at index 3 when length nonzero.
// [R10] Port register bits 7:4 read zero.
// [R11] Vendor length defaults zero, at most 64.
// [R12] String bytes go out in ascending order.
package hcsr_pkg;
    // -------------------------------------------------------------------------
    // Register offsets
    // -------------------------------------------------------------------------
    localparam logic [7:0] HCSR_OFF_VENDOR_LEN  = 8'h23;
    localparam logic [7:0] HCSR_OFF_DEV_CFG3    = 8'h25;
    localparam logic [7:0] HCSR_OFF_PORT_LEGACY = 8'h26;
    localparam logic [7:0] HCSR_OFF_SERIAL_BASE = 8'h30;
    localparam logic [7:0] HCSR_OFF_VENDOR_BASE = 8'h50;
    // -------------------------------------------------------------------------
    // Fields, sizes and reset values
    // -------------------------------------------------------------------------
    localparam int         HCSR_CFG3_LEGACY_BIT = 4;
    localparam int         HCSR_CFG3_AUTO_BIT   = 0;
    localparam int         HCSR_NUM_PORTS       = 4;
    localparam int         HCSR_SERIAL_BYTES    = 32;
    localparam int         HCSR_VENDOR_BYTES    = 64;
    localparam logic [6:0] HCSR_VENDOR_LEN_MAX  = 7'h40;
    localparam logic [6:0] HCSR_VENDOR_LEN_RST  = 7'h00;
    localparam logic [3:0] HCSR_PORT_LEGACY_RST = 4'h0;
    localparam logic       HCSR_CFG3_BIT_RST    = 1'b0;
    localparam logic [7:0] HCSR_VENDOR_BYTE_RST = 8'h00;
    localparam logic [7:0] HCSR_STR_IDX_SERIAL  = 8'h01;
    localparam logic [7:0] HCSR_STR_IDX_VENDOR  = 8'h03;
    // -------------------------------------------------------------------------
    // Charging attempt states, Gray coded along the attempt order
    // -------------------------------------------------------------------------
    typedef enum logic [1:0] {
        HCSR_CHG_IDLE   = 2'h0,
        HCSR_CHG_DIV_HI = 2'h1,
        HCSR_CHG_DIV_LO = 2'h3,
        HCSR_CHG_DCP    = 2'h2
    } hcsr_chg_state_t;
endpackage

// ==== hw/hcsr_charge_seq.sv ====
// Purpose: Per-port automatic charging mode sequencer.
// Assumes: Attempt failure pulses come from charger detect logic on i_clk.
// Notes:   Dropping i_active returns the port to idle at once.
`timescale 1ns/100ps
module hcsr_charge_seq
    import hcsr_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    input  wire logic       i_active,
    input  wire logic       i_full_auto,
    input  wire logic       i_attempt_fail,
    output logic      [1:0] o_mode
);
    hcsr_chg_state_t state_r;
    hcsr_chg_state_t state_nxt;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            HCSR_CHG_IDLE:   state_nxt = i_full_auto ? HCSR_CHG_DIV_HI : HCSR_CHG_DCP; // see [R3]
            HCSR_CHG_DIV_HI: if (i_attempt_fail) state_nxt = HCSR_CHG_DIV_LO; // see [R3]
            HCSR_CHG_DIV_LO: if (i_attempt_fail) state_nxt = HCSR_CHG_DCP; // see [R3]
            HCSR_CHG_DCP:    state_nxt = HCSR_CHG_DCP;
        endcase
        if (!i_active) begin
            state_nxt = HCSR_CHG_IDLE;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_r <= HCSR_CHG_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign o_mode = state_r;

    // -------------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------------
    property p_high_first;
        @(posedge i_clk) disable iff (i_reset)
        (state_r == HCSR_CHG_IDLE) && i_active && i_full_auto |=> o_mode == HCSR_CHG_DIV_HI;
    endproperty
    a_high_first: assert property (p_high_first) else $error("high divider not tried first"); // see [R3]

    property p_no_skip;
        @(posedge i_clk) disable iff (i_reset)
        (state_r == HCSR_CHG_DIV_HI) && i_active ##1 (state_r != HCSR_CHG_DIV_HI)
            |-> state_r == HCSR_CHG_DIV_LO;
    endproperty
    a_no_skip: assert property (p_no_skip) else $error("low divider mode skipped"); // see [R3]
endmodule

// ==== hw/hcsr_desc_stream.sv ====
// Purpose: Streams one string descriptor body byte by byte.
// Assumes: The byte at o_ptr of source o_src is supplied back on i_byte.
// Notes:   Requests while a string is in flight are ignored.
`timescale 1ns/100ps
module hcsr_desc_stream
    import hcsr_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    input  wire logic       i_req,
    input  wire logic [7:0] i_index,
    input  wire logic [6:0] i_vendor_len,
    input  wire logic       i_ready,
    input  wire logic [7:0] i_byte,
    output logic            o_src,
    output logic      [6:0] o_ptr,
    output logic            o_busy,
    output logic            o_valid,
    output logic      [7:0] o_byte,
    output logic            o_last,
    output logic            o_none
);
    logic       busy_r;
    logic       src_r;
    logic [6:0] ptr_r;
    logic [6:0] len_r;
    logic       valid_r;
    logic [7:0] byte_r;
    logic       last_r;
    logic       none_r;
    wire        idle      = !busy_r && !valid_r;
    wire        take      = valid_r && i_ready;
    wire        load      = busy_r && (!valid_r || take);
    wire        at_end    = ptr_r == 7'(len_r - 7'h01);
    wire        want_ser  = i_req && idle && (i_index == HCSR_STR_IDX_SERIAL); // see [R7]
    wire        want_ven  = i_req && idle && (i_index == HCSR_STR_IDX_VENDOR)
                            && (i_vendor_len != 7'h00); // see [R9]

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            busy_r  <= 1'b0;
            src_r   <= 1'b0;
            ptr_r   <= 7'h00;
            len_r   <= 7'h00;
            valid_r <= 1'b0;
            byte_r  <= 8'h00;
            last_r  <= 1'b0;
            none_r  <= 1'b0;
        end else begin
            none_r  <= i_req && idle && !want_ser && !want_ven;
            valid_r <= load || (valid_r && !take);
            if (want_ser || want_ven) begin
                busy_r <= 1'b1;
                src_r  <= want_ven;
                ptr_r  <= 7'h00; // see [R12]
                len_r  <= want_ven ? i_vendor_len : 7'(HCSR_SERIAL_BYTES); // see [R9]
            end else if (load) begin
                byte_r <= i_byte;
                last_r <= at_end;
                ptr_r  <= 7'(ptr_r + 7'h01); // see [R12]
                busy_r <= !at_end;
            end
        end
    end

    assign o_src   = src_r;
    assign o_ptr   = ptr_r;
    assign o_busy  = busy_r;
    assign o_valid = valid_r;
    assign o_byte  = byte_r;
    assign o_last  = last_r;
    assign o_none  = none_r;

    property p_ascending;
        @(posedge i_clk) disable iff (i_reset)
        load |=> ptr_r == 7'($past(ptr_r) + 7'h01);
    endproperty
    a_ascending: assert property (p_ascending) else $error("string byte order broken"); // see [R12]
endmodule

// ==== dv/hcsr_cfg_host.sv ====
// Purpose: Configuration host model on the register port.
// Assumes: Requests change at the falling edge, one byte per access.
// Notes:   Released address and data are inverted so stale values never match.
`timescale 1ns/100ps
module hcsr_cfg_host (
    input  wire logic       i_clk,
    output logic            o_wr    = 1'b0,
    output logic            o_rd    = 1'b0,
    output logic      [7:0] o_addr  = 8'h00,
    output logic      [7:0] o_wdata = 8'h00,
    input  wire logic [7:0] i_rdata,
    input  wire logic       i_rvalid
);
    // -----------------------------------------
    // Host accesses
    // -----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        o_addr = a;
        o_wdata = d;
        o_wr = 1'b1;
        @(negedge i_clk);
        o_wr = 1'b0;
        o_addr = ~a;
        o_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge i_clk);
        o_addr = a;
        o_rd = 1'b1;
        @(negedge i_clk);
        o_rd = 1'b0;
        o_addr = ~a;
        d = i_rdata;
        v = i_rvalid;
    endtask
endmodule

// ==== dv/hcsr_tb.sv ====
// Purpose: Self-checking bench for the hub configuration registers.
// Assumes: Inputs change at the falling clock edge.
// Notes:   Register traffic goes through the host model.
`timescale 1ns/100ps
module testbench
    import hcsr_pkg::*;
;
    localparam logic [255:0] SER = {8{32'h1F2E3D4C}};
    logic clk, rst = 1'b1, c_rm = 1'b0, c_sn = 1'b0, c_st = 1'b0, f_leg = 1'b0;
    logic auto_act = 1'b0, dreq = 1'b0, drdy = 1'b1, wr, rd, rvalid, spd5, hub_en, dval, dlast;
    logic dnone, dbusy;
    logic [3:0] flag_a = 4'h0, att_fail = 4'h0, leg, ss_en;
    logic [7:0] didx = 8'h00, addr, wdata, rdata, cmode, dbyte, rv;
    logic [7:0] cm [3] = '{8'h01, 8'h03, 8'h02};
    logic [7:0] exp_q [$];
    int bad_count, compares, cycles;
    hcsr_cfg_host hcsr_cfg_host_inst (.i_clk(clk), .o_wr(wr), .o_rd(rd), .o_addr(addr),
        .o_wdata(wdata), .i_rdata(rdata), .i_rvalid(rvalid));
    hcsr_regs #(.SERIAL_DEFAULT(SER)) hcsr_regs_inst (.i_clk(clk), .i_reset(rst),
        .i_cfg_wr(wr), .i_cfg_rd(rd), .i_cfg_addr(addr), .i_cfg_wdata(wdata),
        .o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid), .i_custom_removable_control(c_rm),
        .i_custom_serial_control(c_sn), .i_custom_strings_control(c_st),
        .i_fuse_hub_legacy_only(f_leg), .i_fuse_full_auto_divider_charging(1'b0),
        .i_port_flag_a(flag_a), .i_port_charge_enable(4'h1), .i_auto_charge_active(auto_act),
        .i_charge_attempt_fail(att_fail), .o_ss_speed_5g_supported(spd5),
        .o_ss_hub_enable(hub_en), .o_port_legacy_only(leg), .o_port_ss_enable(ss_en),
        .o_port_charge_mode(cmode), .i_desc_req(dreq), .i_desc_index(didx),
        .i_desc_ready(drdy), .o_desc_valid(dval), .o_desc_byte(dbyte),
        .o_desc_last(dlast), .o_desc_busy(dbusy), .o_desc_none(dnone));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            stop_test();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        hcsr_cfg_host_inst.wr(a, d);
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic v;
        hcsr_cfg_host_inst.rd(a, rv, v);
        chk({7'h00, v}, 8'h01);
        chk(rv, e);
    endtask
    // A stream is fetched with the consumer stalling once on the first byte; an empty
    // queue expects refusal.
    task automatic strm(input logic [7:0] idx);
        int n;
        @(negedge clk);
        dreq = 1'b1;
        didx = idx;
        drdy = 1'b0;
        @(negedge clk);
        dreq = 1'b0;
        chk({6'h00, dbusy, dnone}, {6'h00, exp_q.size() != 0, exp_q.size() == 0});
        while (exp_q.size() > 0) begin
            n = 0;
            while (dval !== 1'b1 && n < 8) begin
                @(negedge clk);
                n++;
            end
            // One edge with ready low shows that the offered byte stands until taken.
            if (!drdy) begin
                @(negedge clk);
                drdy = 1'b1;
            end
            chk({6'h00, dval, dlast}, {7'h01, exp_q.size() == 1});
            chk(dbyte, exp_q.pop_front());
            @(negedge clk);
        end
        chk({6'h00, dval, dbusy}, 8'h00);
        drdy = 1'b1;
        $display("test string %0d done", idx);
    endtask
    task automatic stop_test;
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        rc(HCSR_OFF_VENDOR_LEN, 8'h00);
        rc(8'hF0, 8'h00);
        chk({6'h00, spd5, hub_en}, 8'h03);
        f_leg = 1'b1;
        rc(HCSR_OFF_DEV_CFG3, 8'h10);
        chk({6'h00, spd5, hub_en}, 8'h00);
        f_leg = 1'b0;
        w(HCSR_OFF_DEV_CFG3, 8'h11);
        rc(HCSR_OFF_DEV_CFG3, 8'h11);
        chk({7'h00, spd5}, 8'h00);
        auto_act = 1'b1;
        for (int i = 0; i < 3; i++) begin
            @(negedge clk);
            att_fail = 4'h0;
            @(negedge clk);
            chk({6'h00, cmode[1:0]}, cm[i]);
            att_fail = 4'h1;
        end
        auto_act = 1'b0;
        att_fail = 4'h0;
        // Without full auto the port goes straight to DCP.
        w(HCSR_OFF_DEV_CFG3, 8'h10);
        auto_act = 1'b1;
        @(negedge clk);
        chk({6'h00, cmode[1:0]}, 8'h02);
        auto_act = 1'b0;
        $display("test cfg and charging done");
        flag_a = 4'hF;
        w(HCSR_OFF_PORT_LEGACY, 8'hFF);
        rc(HCSR_OFF_PORT_LEGACY, 8'h00);
        c_rm = 1'b1;
        w(HCSR_OFF_PORT_LEGACY, 8'hF5);
        rc(HCSR_OFF_PORT_LEGACY, 8'h05);
        chk({leg, ss_en}, 8'h5A);
        $display("test port done");
        w(HCSR_OFF_SERIAL_BASE, 8'hA5);
        rc(HCSR_OFF_SERIAL_BASE, SER[7:0]);
        c_sn = 1'b1;
        w(HCSR_OFF_SERIAL_BASE + 8'h1F, 8'hA5);
        for (int i = 0; i < 31; i++) exp_q.push_back(SER[8*i +: 8]);
        exp_q.push_back(8'hA5);
        strm(HCSR_STR_IDX_SERIAL);
        w(HCSR_OFF_VENDOR_LEN, 8'h03);
        strm(HCSR_STR_IDX_VENDOR);
        c_st = 1'b1;
        w(HCSR_OFF_VENDOR_LEN, 8'h7F);
        rc(HCSR_OFF_VENDOR_LEN, 8'h40);
        w(HCSR_OFF_VENDOR_LEN, 8'h03);
        for (int i = 0; i < 4; i++) w(HCSR_OFF_VENDOR_BASE + 8'(i), 8'hC0 + 8'(i));
        exp_q = '{8'hC0, 8'hC1, 8'hC2};
        strm(HCSR_STR_IDX_VENDOR);
        strm(8'h02);
        stop_test();
    end
endmodule
